// File: dv/pxbar_pin_model.sv
// Purpose: Board side of the port pins.
// Assumes: Each pin has a weak pull-up.
// Notes: Outside drive only reaches pins the crossbar releases.
`timescale 1ns/1ps

module pxbar_pin_model (
  input wire logic [15:0] i_out,
  input wire logic [15:0] i_oe_n,
  input wire logic [15:0] i_ext_val,
  input wire logic [15:0] i_ext_en,
  output logic [15:0] o_pin
);
  // A released pin with no outside driver rests at the pull-up level.
  assign o_pin = (~i_oe_n & i_out) |
    (i_oe_n & ((i_ext_en & i_ext_val) | ~i_ext_en));
endmodule

// File: dv/pxbar_top_bench.sv
// Purpose: Register and pin scenarios for the pin crossbar.
// Assumes: Pin outputs settle two edges after a register write.
// Notes: Pin levels come from the pin model.
`timescale 1ns/1ps
`include "pxbar_defs.svh"

module pxbar_top_bench;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  pxbar_pkg::pxbar_bus_s bus = '0;
  pxbar_pkg::pxbar_fn_s fn = {17'h00124, 17'h1FFF5};
  logic [15:0] pin, out, oe_n;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] ext_en = 16'h0000;
  logic [7:0] rdata;
  logic [16:0] fn_in;
  int fails = 0;
  int check_count = 0;
  logic [7:0] sk [4] = '{8'h00, 8'h00, 8'h00, 8'h05};
  logic [7:0] cf [4] = '{8'h01, 8'h03, 8'h03, 8'h01};
  logic [16:0] vl [4] = '{17'h124, 17'h124, 17'h164, 17'h124};
  logic [31:0] eo [4] = '{32'hFF02, 32'hFF02, 32'hFF12, 32'hFF08};
  logic [31:0] ev [4] = '{32'hE1, 32'hC9, 32'hC9, 32'h87};

  // Clock of 4 ns.
  always #2 i_clk = ~i_clk;

  pxbar_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus),
    .o_rd_data(rdata), .i_fn(fn), .o_fn_in(fn_in), .i_pin(pin),
    .o_pin_out(out), .o_pin_oe_n(oe_n));
  pxbar_pin_model u_pins (.i_out(out), .i_oe_n(oe_n), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_pin(pin));

  // ------------
  // Tasks
  // ------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    chk(32'(rdata), 32'(exp));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ------------
  // Scenarios
  // ------------
  // Watchdog in case a scenario stalls.
  initial begin
    #20000;
    fails++;
    complete_run();
  end

  // Main sequence; pins settle two edges after a write.
  initial begin
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`PX_ADDR_ROUTE0, 8'h00); // reset value.
    rd(8'h10, 8'h00); // unmapped offset reads zero.
    chk(32'(oe_n), 32'hFFFF); // outputs off.
    wr(`PX_ADDR_ROUTE0, 8'hFF);
    rd(`PX_ADDR_ROUTE0, 8'h3F); // top bits dropped.
    wr(`PX_ADDR_ROUTE0, 8'h01);
    wr(`PX_ADDR_SKIP0, 8'h30);
    wr(`PX_ADDR_SKIP1, 8'h10); // unbonded pin skipped.
    idle(2);
    chk(32'(oe_n), 32'hFFFF); // disabled crossbar.
    $display("test registers done");
    wr(`PX_ADDR_CFG, 8'h01);
    ext_en <= 16'hFFFF;
    idle(4);
    chk(32'({oe_n[5:4], out[4], fn_in[1]}), 32'h8); // fixed pins.
    $display("test uart done");
    wr(`PX_ADDR_SKIP0, 8'h00);
    wr(`PX_ADDR_MODE0, 8'hFF);
    wr(`PX_ADDR_ROUTE0, 8'h04);
    idle(2);
    chk(32'(oe_n), 32'hFF00); // all eight port 0 pins driven.
    chk(32'(out & ~oe_n), 32'hFC); // low lines.
    rd(`PX_ADDR_USED0, 8'h03); // two pins claimed.
    rd(`PX_ADDR_USED1, 8'h00); // skipped pin not claimed.
    wr(`PX_ADDR_ROUTE0, 8'h16);
    for (int i = 0; i < 4; i++) begin
      wr(`PX_ADDR_SKIP0, sk[i]);
      wr(`PX_ADDR_CFG, cf[i]);
      fn.val <= vl[i];
      idle(2);
      chk(32'(oe_n), eo[i]); // placement.
      chk(32'(out & ~oe_n), ev[i]); // driven values.
    end
    $display("test serial done");
    wr(`PX_ADDR_SKIP0, 8'h00);
    wr(`PX_ADDR_MODE0, 8'h00);
    wr(`PX_ADDR_ROUTE0, 8'h38);
    wr(`PX_ADDR_ROUTEX, 8'h3B);
    fn <= {17'h01500, 17'h03F00};
    ext_val <= 16'h0080;
    idle(4);
    chk(32'(oe_n), 32'hFFC0); // lower order.
    chk(32'(out & ~oe_n), 32'h15); // outputs placed.
    chk(32'(fn_in[16:14]), 32'h2); // inputs placed.
    $display("test low priority done");
    complete_run();
  end
endmodule

// File: dv/pxbar_top_monitor.sv
// Purpose: Port-level timing and value checks of the pin crossbar.
// Assumes: Shadows of the setup registers follow bus writes.
// Notes: Bound into pxbar_top below.
`timescale 1ns/1ps
`include "pxbar_defs.svh"

module pxbar_top_monitor (
  input wire logic i_clk,
  input wire logic i_nrst,
  input pxbar_pkg::pxbar_bus_s i_bus,
  input wire logic [7:0] o_rd_data,
  input pxbar_pkg::pxbar_fn_s i_fn,
  input wire logic [16:0] o_fn_in,
  input wire logic [15:0] i_pin,
  input wire logic [15:0] o_pin_out,
  input wire logic [15:0] o_pin_oe_n
);
  // ------------
  // Shadows
  // ------------
  logic [5:0] route_q;
  logic [2:0] cfg_q;
  logic [15:0] skip_q;

  // Shadows let pin checks know the setup without peeking inside.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      route_q <= 6'h00;
      cfg_q <= 3'h0;
      skip_q <= 16'h0000;
    end else if (i_bus.wr) begin
      if (i_bus.addr == `PX_ADDR_ROUTE0) route_q <= i_bus.wdata[5:0];
      if (i_bus.addr == `PX_ADDR_CFG) cfg_q <= i_bus.wdata[2:0];
      if (i_bus.addr == `PX_ADDR_SKIP0) skip_q[7:0] <= i_bus.wdata;
      if (i_bus.addr == `PX_ADDR_SKIP1) skip_q[15:8] <= i_bus.wdata;
    end
  end

  // ------------
  // Properties
  // ------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_rd_route;
    i_bus.rd && i_bus.addr == `PX_ADDR_ROUTE0 |=>
      o_rd_data == {2'b00, $past(route_q)};
  endproperty
  a_rd_route: assert property (p_rd_route)
    else $error("route register read back wrong");
  property p_rd_top;
    $past(i_bus.rd && i_bus.addr == `PX_ADDR_ROUTE0) |->
      o_rd_data[7:6] == 2'b00;
  endproperty
  a_rd_top: assert property (p_rd_top)
    else $error("unused route bits read nonzero");
  property p_rd_idle;
    !$past(i_bus.rd) |-> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its cycle");
  property p_gen_off;
    !$past(cfg_q[0]) |-> o_pin_oe_n == 16'hFFFF;
  endproperty
  a_gen_off: assert property (p_gen_off)
    else $error("pin driven while crossbar disabled");
  property p_tx;
    $past(cfg_q[0] && route_q[0] && i_fn.drv[0]) |->
      o_pin_out[4] == $past(i_fn.val[0]) && !o_pin_oe_n[4];
  endproperty
  a_tx: assert property (p_tx)
    else $error("transmit line not on its fixed pin");
  property p_rx;
    $past(cfg_q[0] && route_q[0]) |-> o_fn_in[1] == $past(i_pin[5], 3);
  endproperty
  a_rx: assert property (p_rx)
    else $error("receive line not taken from its fixed pin");
  property p_rx_off;
    !$past(route_q[0]) |-> o_fn_in[1] == 1'b1;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive line seen while unrouted");
  property p_nss3;
    $past(cfg_q[2:1] == 2'h0) |-> o_fn_in[5] == 1'b1;
  endproperty
  a_nss3: assert property (p_nss3)
    else $error("select routed in three-wire mode");
  property p_smb_od;
    $past(cfg_q[0] && route_q == 6'h04 && skip_q[1:0] == 2'h0) |->
      o_pin_oe_n[1:0] == ~($past(i_fn.drv[7:6]) & ~$past(i_fn.val[7:6]));
  endproperty
  a_smb_od: assert property (p_smb_od)
    else $error("bus pins not open drain");
endmodule

bind pxbar_top pxbar_top_monitor u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_bus(i_bus), .o_rd_data(o_rd_data), .i_fn(i_fn), .o_fn_in(o_fn_in),
  .i_pin(i_pin), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n));

// File: hw/pxbar_assign.sv
// Purpose: Priority pin assignment of enabled functions to crossbar pins.
// Assumes: Enables already reflect pairing and SPI mode.
// Notes: Purely combinational; the caller registers the results.
`timescale 1ns/1ps
`include "pxbar_defs.svh"

module pxbar_assign (
  input wire logic [16:0] i_fn_en,
  input wire logic [15:0] i_skip,
  output pxbar_pkg::pxbar_fnidx_t o_pin_fn [16],
  output logic [15:0] o_pin_used,
  output pxbar_pkg::pxbar_pinidx_t o_fn_pin [17],
  output logic [16:0] o_fn_hit
);

  // Lowest pin not yet claimed, or the none code when all are taken.
  function automatic logic [4:0] first_free(input logic [15:0] claimed);
    logic [4:0] idx;
    idx = `PX_NONE;
    for (int p = 15; p >= 0; p--) begin
      if (!claimed[p]) begin
        idx = 5'(p);
      end
    end
    return idx;
  endfunction

  // Walk the functions in priority order; UART takes fixed pins 4 and 5, each other line the lowest free pin.
  always_comb begin
    logic [15:0] claimed;
    logic [4:0] idx;
    claimed = i_skip;
    idx = `PX_NONE;
    o_pin_used = '0;
    o_fn_hit = '0;
    for (int p = 0; p < `PX_NPINS; p++) begin
      o_pin_fn[p] = '0;
    end
    for (int f = 0; f < `PX_NFN; f++) begin
      o_fn_pin[f] = '0;
    end
    if (i_fn_en[`PX_F_TX]) begin
      claimed[`PX_UART_TX_PIN] = 1'b1;
      claimed[`PX_UART_RX_PIN] = 1'b1;
      o_pin_used[`PX_UART_TX_PIN] = 1'b1;
      o_pin_used[`PX_UART_RX_PIN] = 1'b1;
      o_pin_fn[`PX_UART_TX_PIN] = 5'(`PX_F_TX);
      o_pin_fn[`PX_UART_RX_PIN] = 5'(`PX_F_RX);
      o_fn_pin[`PX_F_TX] = `PX_UART_TX_PIN;
      o_fn_pin[`PX_F_RX] = `PX_UART_RX_PIN;
      o_fn_hit[`PX_F_TX] = 1'b1;
      o_fn_hit[`PX_F_RX] = 1'b1;
    end
    for (int f = `PX_F_SCK; f < `PX_NFN; f++) begin
      if (i_fn_en[f]) begin
        idx = first_free(claimed);
        if (!idx[4]) begin
          claimed[idx[3:0]] = 1'b1;
          o_pin_used[idx[3:0]] = 1'b1;
          o_pin_fn[idx[3:0]] = 5'(f);
          o_fn_pin[f] = idx[3:0];
          o_fn_hit[f] = 1'b1;
        end
      end
    end
  end

endmodule

// File: hw/pxbar_defs.svh
// Purpose: Offsets, fields, reset values and indices of the pin crossbar.
// Assumes: Sixteen crossbar pins, seventeen routable functions.
// Notes: Included by bare name; definitions only.
`ifndef PXBAR_DEFS_SVH
`define PXBAR_DEFS_SVH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define PX_NPINS 16
`define PX_NFN 17
`define PX_NONE 5'h10

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PX_ADDR_ROUTE0 8'hE1
`define PX_ADDR_SKIP0 8'hF0
`define PX_ADDR_SKIP1 8'hF1
`define PX_ADDR_CFG 8'hF2
`define PX_ADDR_ROUTEX 8'hF3
`define PX_ADDR_MODE0 8'hF4
`define PX_ADDR_MODE1 8'hF5
`define PX_ADDR_LATCH0 8'hF6
`define PX_ADDR_LATCH1 8'hF7
`define PX_ADDR_USED0 8'hF8
`define PX_ADDR_USED1 8'hF9

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define PX_ROUTE0_MASK 8'h3F
`define PX_R0_UART 0
`define PX_R0_SPI 1
`define PX_R0_SMB 2
`define PX_R0_SYSCLK 3
`define PX_R0_CMP 4
`define PX_R0_CMPA 5
`define PX_CFG_MASK 8'h07
`define PX_CFG_GEN 0
`define PX_CFG_SPIMODE_LO 1
`define PX_ROUTEX_MASK 8'h3F
`define PX_RX_ECI 3
`define PX_RX_T0 4
`define PX_RX_T1 5
`define PX_RST_BYTE 8'h00
`define PX_RST_LATCH 8'hFF
`define PX_SPI_3WIRE 2'h0
`define PX_UART_TX_PIN 4'h4
`define PX_UART_RX_PIN 4'h5

// ----------------------------------------------------------------------
// Function indices, highest priority first
// ----------------------------------------------------------------------
`define PX_F_TX 0
`define PX_F_RX 1
`define PX_F_SCK 2
`define PX_F_MISO 3
`define PX_F_MOSI 4
`define PX_F_NSS 5
`define PX_F_SDA 6
`define PX_F_SCL 7
`define PX_F_CMP 8
`define PX_F_CMPA 9
`define PX_F_SYSCLK 10
`define PX_F_CAPA 11
`define PX_F_CAPB 12
`define PX_F_CAPC 13
`define PX_F_ECI 14
`define PX_F_T0 15
`define PX_F_T1 16

`endif

// File: hw/pxbar_pkg.sv
// Purpose: Carrier types of the pin crossbar.
// Assumes: Widths match the constants header.
// Notes: Types only; no logic.
package pxbar_pkg;

  // Register port request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pxbar_bus_s;

  // Per-function value and drive request from peripherals.
  typedef struct packed {
    logic [16:0] val;
    logic [16:0] drv;
  } pxbar_fn_s;

  typedef logic [4:0] pxbar_fnidx_t;
  typedef logic [3:0] pxbar_pinidx_t;

endpackage

// File: hw/pxbar_top.sv
// Purpose: Priority crossbar from peripheral signals to sixteen port pins.
// Assumes: Peripheral signals share i_clk; pins are asynchronous.
// Notes: Every route is disabled after reset; pins idle undriven.
`timescale 1ns/1ps
`include "pxbar_defs.svh"

module pxbar_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input pxbar_pkg::pxbar_bus_s i_bus,
  output logic [7:0] o_rd_data,
  input pxbar_pkg::pxbar_fn_s i_fn,
  output logic [16:0] o_fn_in,
  input wire logic [15:0] i_pin,
  output logic [15:0] o_pin_out,
  output logic [15:0] o_pin_oe_n
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  logic [5:0] route0_q;
  logic [15:0] skip_q;
  logic gen_q;
  logic [1:0] spi_mode_q;
  logic [2:0] cap_mode_q;
  logic eci_en_q;
  logic t0_en_q;
  logic t1_en_q;
  logic [15:0] mode_q;
  logic [15:0] latch_q;
  logic [7:0] rd_data_q;

  // --------------------------------------------------------------------
  // Assignment state
  // --------------------------------------------------------------------
  logic [15:0] pin_meta_q;
  logic [15:0] pin_sync_q;
  logic [16:0] fn_en;
  pxbar_pkg::pxbar_fnidx_t pin_fn [16];
  logic [15:0] pin_used;
  pxbar_pkg::pxbar_pinidx_t fn_pin [17];
  logic [16:0] fn_hit;
  logic [15:0] pin_out_d;
  logic [15:0] pin_drv_d;
  logic [16:0] fn_in_d;
  logic [7:0] rd_data_d;

  // True when a write strobe targets the given offset.
  function automatic logic wr_hit(input pxbar_pkg::pxbar_bus_s bus,
                                  input logic [7:0] addr);
    return bus.wr && (bus.addr == addr);
  endfunction

  // True for the two SMBus functions, which are always open-drain.
  function automatic logic is_smbus(input logic [4:0] f);
    return (f == 5'(`PX_F_SDA)) || (f == 5'(`PX_F_SCL));
  endfunction

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------

  // Route register; the unused top bits are never stored.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      route0_q <= 6'h00;
    end else if (wr_hit(i_bus, `PX_ADDR_ROUTE0)) begin
      route0_q <= i_bus.wdata[5:0];
    end
  end

  // Skip masks, one byte per port.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      skip_q <= {`PX_RST_BYTE, `PX_RST_BYTE};
    end else begin
      if (wr_hit(i_bus, `PX_ADDR_SKIP0)) begin
        skip_q[7:0] <= i_bus.wdata;
      end
      if (wr_hit(i_bus, `PX_ADDR_SKIP1)) begin
        skip_q[15:8] <= i_bus.wdata;
      end
    end
  end

  // Global enable and SPI select mode.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      gen_q <= 1'b0;
      spi_mode_q <= `PX_SPI_3WIRE;
    end else if (wr_hit(i_bus, `PX_ADDR_CFG)) begin
      gen_q <= i_bus.wdata[`PX_CFG_GEN];
      spi_mode_q <= i_bus.wdata[`PX_CFG_SPIMODE_LO +: 2];
    end
  end

  // Capture line count and timer input enables.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cap_mode_q <= 3'h0;
      eci_en_q <= 1'b0;
      t0_en_q <= 1'b0;
      t1_en_q <= 1'b0;
    end else if (wr_hit(i_bus, `PX_ADDR_ROUTEX)) begin
      cap_mode_q <= i_bus.wdata[2:0];
      eci_en_q <= i_bus.wdata[`PX_RX_ECI];
      t0_en_q <= i_bus.wdata[`PX_RX_T0];
      t1_en_q <= i_bus.wdata[`PX_RX_T1];
    end
  end

  // Output modes (1 is push-pull) and general purpose output latches.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mode_q <= {`PX_RST_BYTE, `PX_RST_BYTE};
      latch_q <= {`PX_RST_LATCH, `PX_RST_LATCH};
    end else begin
      if (wr_hit(i_bus, `PX_ADDR_MODE0)) begin
        mode_q[7:0] <= i_bus.wdata;
      end
      if (wr_hit(i_bus, `PX_ADDR_MODE1)) begin
        mode_q[15:8] <= i_bus.wdata;
      end
      if (wr_hit(i_bus, `PX_ADDR_LATCH0)) begin
        latch_q[7:0] <= i_bus.wdata;
      end
      if (wr_hit(i_bus, `PX_ADDR_LATCH1)) begin
        latch_q[15:8] <= i_bus.wdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------

  // Read mux; unmapped offsets answer zero.
  always_comb begin
    case (i_bus.addr)
      `PX_ADDR_ROUTE0: rd_data_d = {2'b00, route0_q};
      `PX_ADDR_SKIP0: rd_data_d = skip_q[7:0];
      `PX_ADDR_SKIP1: rd_data_d = skip_q[15:8];
      `PX_ADDR_CFG: rd_data_d = {5'h00, spi_mode_q, gen_q};
      `PX_ADDR_ROUTEX:
        rd_data_d = {2'b00, t1_en_q, t0_en_q, eci_en_q, cap_mode_q};
      `PX_ADDR_MODE0: rd_data_d = mode_q[7:0];
      `PX_ADDR_MODE1: rd_data_d = mode_q[15:8];
      `PX_ADDR_LATCH0: rd_data_d = latch_q[7:0];
      `PX_ADDR_LATCH1: rd_data_d = latch_q[15:8];
      `PX_ADDR_USED0: rd_data_d = pin_used[7:0];
      `PX_ADDR_USED1: rd_data_d = pin_used[15:8];
      default: rd_data_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rd_data_q <= 8'h00;
    end else if (i_bus.rd) begin
      rd_data_q <= rd_data_d;
    end else begin
      rd_data_q <= 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Function enables
  // --------------------------------------------------------------------

  // Pairing and SPI mode are folded in here, so the assigner sees
  // exactly the set of lines that must land on pins.
  always_comb begin
    fn_en = '0;
    fn_en[`PX_F_TX] = route0_q[`PX_R0_UART];
    fn_en[`PX_F_RX] = route0_q[`PX_R0_UART];
    fn_en[`PX_F_SCK] = route0_q[`PX_R0_SPI];
    fn_en[`PX_F_MISO] = route0_q[`PX_R0_SPI];
    fn_en[`PX_F_MOSI] = route0_q[`PX_R0_SPI];
    fn_en[`PX_F_NSS] = route0_q[`PX_R0_SPI] &&
                       (spi_mode_q != `PX_SPI_3WIRE);
    fn_en[`PX_F_SDA] = route0_q[`PX_R0_SMB];
    fn_en[`PX_F_SCL] = route0_q[`PX_R0_SMB];
    fn_en[`PX_F_CMP] = route0_q[`PX_R0_CMP];
    fn_en[`PX_F_CMPA] = route0_q[`PX_R0_CMPA];
    fn_en[`PX_F_SYSCLK] = route0_q[`PX_R0_SYSCLK];
    // Reserved capture codes route nothing.
    fn_en[`PX_F_CAPA] = (cap_mode_q >= 3'h1) && (cap_mode_q <= 3'h3);
    fn_en[`PX_F_CAPB] = (cap_mode_q >= 3'h2) && (cap_mode_q <= 3'h3);
    fn_en[`PX_F_CAPC] = (cap_mode_q == 3'h3);
    fn_en[`PX_F_ECI] = eci_en_q;
    fn_en[`PX_F_T0] = t0_en_q;
    fn_en[`PX_F_T1] = t1_en_q;
  end

  pxbar_assign u_assign (
    .i_fn_en(fn_en),
    .i_skip(skip_q),
    .o_pin_fn(pin_fn),
    .o_pin_used(pin_used),
    .o_fn_pin(fn_pin),
    .o_fn_hit(fn_hit)
  );

  // --------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------

  // Per-pin value and drive, before the output flops.
  always_comb begin
    for (int p = 0; p < `PX_NPINS; p++) begin
      if (pin_used[p]) begin
        if (is_smbus(pin_fn[p])) begin
          pin_out_d[p] = 1'b0;
          pin_drv_d[p] = i_fn.drv[pin_fn[p]] && !i_fn.val[pin_fn[p]];
        end else begin
          pin_out_d[p] = i_fn.val[pin_fn[p]];
          pin_drv_d[p] = i_fn.drv[pin_fn[p]];
        end
      end else begin
        pin_out_d[p] = latch_q[p];
        pin_drv_d[p] = mode_q[p] || !latch_q[p];
      end
      if (!gen_q) begin
        pin_drv_d[p] = 1'b0;
      end
    end
  end

  // Registered pin outputs; the enable is low while driving.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pin_out <= 16'hFFFF;
      o_pin_oe_n <= 16'hFFFF;
    end else begin
      o_pin_out <= pin_out_d;
      o_pin_oe_n <= ~pin_drv_d;
    end
  end

  // --------------------------------------------------------------------
  // Pin inputs back to peripherals
  // --------------------------------------------------------------------

  // Two-stage synchroniser; only the second stage is read.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin_meta_q <= 16'hFFFF;
      pin_sync_q <= 16'hFFFF;
    end else begin
      pin_meta_q <= i_pin;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Unrouted functions see an idle high level, which keeps serial
  // receivers and counter inputs quiet while they are off the pins.
  always_comb begin
    for (int f = 0; f < `PX_NFN; f++) begin
      fn_in_d[f] = fn_hit[f] ? pin_sync_q[fn_pin[f]] : 1'b1;
    end
  end

  // Registered function inputs.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fn_in <= 17'h1FFFF;
    end else begin
      o_fn_in <= fn_in_d;
    end
  end

  assign o_rd_data = rd_data_q;

endmodule
